// ### rtl/cdl_params.svh
`ifndef CDL_PARAMS_SVH
`define CDL_PARAMS_SVH

// register byte offsets
`define CDL_OFS_CTRL        8'h00
`define CDL_OFS_ADDEND      8'h04
`define CDL_OFS_ACCUM       8'h08
`define CDL_OFS_STATUS      8'h0C

// control register layout
`define CDL_CTRL_MODE_HI    30
`define CDL_CTRL_MODE_LO    26

// status register layout
`define CDL_ST_FIRST_S1     0
`define CDL_ST_FIRST_S2     1
`define CDL_ST_SECOND_S1    2
`define CDL_ST_FIRST_OUT    3
`define CDL_ST_SECOND_OUT   4
`define CDL_ST_CARRY        5
`define CDL_ST_ACC_EN       6

// reset values
`define CDL_RST_WORD        32'h0000_0000
`define CDL_RST_MODE        5'h00

// mode codes
`define CDL_MODE_OFF        5'h00
`define CDL_MODE_NCO_SE     5'h04
`define CDL_MODE_NCO_DIFF   5'h05
`define CDL_MODE_DUTY_SE    5'h06
`define CDL_MODE_DUTY_DIFF  5'h07
`define CDL_MODE_LOGIC_NEVER 5'h10
`define CDL_MODE_LOGIC_ALWAYS 5'h1F

// logic truth codes reused by pin-state level modes
`define CDL_TRUTH_FIRST_HI  4'hA
`define CDL_TRUTH_FIRST_LO  4'h5

`endif

// ### rtl/cdl_pkg.sv
package cdl_pkg;

   typedef logic [4:0]  cdl_mode_t;
   typedef logic [31:0] cdl_word_t;

   typedef enum logic [2:0] {
      CDL_GRP_OFF   = 3'h0,
      CDL_GRP_PLL   = 3'h1,
      CDL_GRP_NCO   = 3'h2,
      CDL_GRP_DUTY  = 3'h3,
      CDL_GRP_PIN   = 3'h4,
      CDL_GRP_LOGIC = 3'h5
   } cdl_group_t;

   // truth table indexed by {second, first}
   function automatic logic cdl_truth(input logic [3:0] code,
                                      input logic       first,
                                      input logic       second);
      cdl_truth = code[{second, first}];
   endfunction : cdl_truth

   // byte-lane merge for a bus write
   function automatic cdl_word_t cdl_merge(input cdl_word_t  old_v,
                                           input cdl_word_t  new_v,
                                           input logic [3:0] sel);
      cdl_word_t r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      cdl_merge = r;
   endfunction : cdl_merge

endpackage : cdl_pkg

// ### rtl/cdl_acc_if.sv
`timescale 1ns/1ps
interface cdl_acc_if;
   cdl_pkg::cdl_word_t addend;
   cdl_pkg::cdl_word_t wdata;
   logic               wr;
   logic               acc_en;
   cdl_pkg::cdl_word_t accum;
   cdl_pkg::cdl_word_t next_accum;
   logic               carry;

   modport ctl (output addend, output wdata, output wr, output acc_en,
                input accum, input next_accum, input carry);
   modport acc (input addend, input wdata, input wr, input acc_en,
                output accum, output next_accum, output carry);
endinterface : cdl_acc_if

// ### rtl/cdl_cond.sv
`timescale 1ns/1ps
`include "cdl_params.svh"
module cdl_cond (
   // mode
   input  wire cdl_pkg::cdl_mode_t  mode,
   // registered pin samples
   input  wire logic                first_s1,
   input  wire logic                first_s2,
   input  wire logic                second_s1,
   // decision
   output cdl_pkg::cdl_group_t      grp,
   output logic                     acc_en
);
   logic rise;
   logic fall;

   assign rise = first_s1 & ~first_s2; // R12
   assign fall = ~first_s1 & first_s2; // R12

   always_comb begin
      grp    = cdl_pkg::CDL_GRP_OFF;
      acc_en = 1'b0;
      unique casez (mode)
         5'b00000: begin
            grp    = cdl_pkg::CDL_GRP_OFF;
            acc_en = 1'b0;
         end
         5'b00001, 5'b0001?: begin
            grp    = cdl_pkg::CDL_GRP_PLL;
            acc_en = 1'b1;
         end
         5'b0010?: begin
            grp    = cdl_pkg::CDL_GRP_NCO;
            acc_en = 1'b1; // R15
         end
         5'b0011?: begin
            grp    = cdl_pkg::CDL_GRP_DUTY;
            acc_en = 1'b1; // R2
         end
         5'b01???: begin
            grp = cdl_pkg::CDL_GRP_PIN;
            unique case (mode[2:1])
               2'h0: acc_en = cdl_pkg::cdl_truth(`CDL_TRUTH_FIRST_HI, first_s1, second_s1); // R10 R11 R14
               2'h1: acc_en = rise; // R10
               2'h2: acc_en = cdl_pkg::cdl_truth(`CDL_TRUTH_FIRST_LO, first_s1, second_s1); // R10 R11 R14
               2'h3: acc_en = fall; // R10
            endcase
         end
         5'b1????: begin
            grp    = cdl_pkg::CDL_GRP_LOGIC;
            acc_en = cdl_pkg::cdl_truth(mode[3:0], first_s1, second_s1); // R4 R5 R6 R7 R8 R9
         end
      endcase
   end
endmodule : cdl_cond

// ### rtl/cdl_accum.sv
`timescale 1ns/1ps
`include "cdl_params.svh"
module cdl_accum (
   // clock and reset
   input  wire logic CORE_CLK,
   input  wire logic RESETN,
   // control side
   cdl_acc_if.acc    acc_io
);
   logic [32:0]        sum;
   cdl_pkg::cdl_word_t accum;

   assign sum               = {1'b0, accum} + {1'b0, acc_io.addend}; // R17
   assign acc_io.carry      = acc_io.acc_en & sum[32]; // R1
   assign acc_io.accum      = accum;
   assign acc_io.next_accum = acc_io.wr ? acc_io.wdata
                            : (acc_io.acc_en ? sum[31:0] : accum);

   // software write wins over accumulation
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         accum <= `CDL_RST_WORD;
      end else begin
         accum <= acc_io.next_accum; // R17
      end
   end
endmodule : cdl_accum

// ### rtl/cdl_counter.sv
`timescale 1ns/1ps
`include "cdl_params.svh"
// Functional notes
// R1: duty mode: carry out drives first pin
// R2: duty mode adds every clock
// R3: duty high fraction equals addend over 2^32
// R4: logic modes: pins inputs, conditional add
// R5: logic never mode never adds
// R6: logic always mode adds every clock
// R7: logic conditions use previous-cycle samples
// R8: logic codes 10001..10111 truth table
// R9: logic codes 11000..11110 truth table
// R10: pin-state modes: level or edge of first
// R11: level modes use single-registered sample
// R12: edge modes compare single and double samples
// R13: odd pin-state modes: second is inverted first
// R14: positive and negative detectors equal logic modes
// R15: nco: add always, top bit to pin
// R16: duty differential: second is inverted carry
// R17: 32-bit wrapping accumulator, software accessible
module cdl_counter (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // first pin
   input  wire logic        FIRST_PIN_I,
   output logic             FIRST_PIN_O,
   output logic             FIRST_PIN_OE,
   // second pin
   input  wire logic        SECOND_PIN_I,
   output logic             SECOND_PIN_O,
   output logic             SECOND_PIN_OE
);
   cdl_acc_if acc_io ();

   cdl_pkg::cdl_mode_t  counter_mode_field;
   cdl_pkg::cdl_word_t  addend;
   cdl_pkg::cdl_group_t grp;
   logic                acc_en;
   logic                first_s1;
   logic                first_s2;
   logic                second_s1;
   logic                carry_q;
   logic                req;
   logic                wr_req;
   logic                next_first_o;
   logic                next_second_o;
   cdl_pkg::cdl_word_t  ctrl_word;
   cdl_pkg::cdl_word_t  status_word;
   cdl_pkg::cdl_word_t  next_rdata;
   cdl_pkg::cdl_word_t  ctrl_merged;

   // bus access decode
   assign req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wr_req = req & WB_WE_I;

   // ack one cycle after request
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= req;
      end
   end

   always_comb begin
      ctrl_word = `CDL_RST_WORD;
      ctrl_word[`CDL_CTRL_MODE_HI:`CDL_CTRL_MODE_LO] = counter_mode_field;
   end

   always_comb begin
      status_word = `CDL_RST_WORD;
      status_word[`CDL_ST_FIRST_S1]   = first_s1;
      status_word[`CDL_ST_FIRST_S2]   = first_s2;
      status_word[`CDL_ST_SECOND_S1]  = second_s1;
      status_word[`CDL_ST_FIRST_OUT]  = FIRST_PIN_O;
      status_word[`CDL_ST_SECOND_OUT] = SECOND_PIN_O;
      status_word[`CDL_ST_CARRY]      = carry_q;
      status_word[`CDL_ST_ACC_EN]     = acc_en;
   end

   always_comb begin
      next_rdata = `CDL_RST_WORD;
      unique case (WB_ADR_I)
         `CDL_OFS_CTRL:   next_rdata = ctrl_word;
         `CDL_OFS_ADDEND: next_rdata = addend;
         `CDL_OFS_ACCUM:  next_rdata = acc_io.accum; // R17
         `CDL_OFS_STATUS: next_rdata = status_word;
         default:         next_rdata = `CDL_RST_WORD;
      endcase
   end

   // read data captured with the request
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         WB_DAT_O <= `CDL_RST_WORD;
      end else if (req && !WB_WE_I) begin
         WB_DAT_O <= next_rdata;
      end
   end

   // byte-merged control word, field picked out below
   assign ctrl_merged = cdl_pkg::cdl_merge(ctrl_word, WB_DAT_I, WB_SEL_I);

   // control register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         counter_mode_field <= `CDL_RST_MODE;
      end else if (wr_req && WB_ADR_I == `CDL_OFS_CTRL) begin
         counter_mode_field <= ctrl_merged[`CDL_CTRL_MODE_HI:`CDL_CTRL_MODE_LO];
      end
   end

   // addend register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         addend <= `CDL_RST_WORD;
      end else if (wr_req && WB_ADR_I == `CDL_OFS_ADDEND) begin
         addend <= cdl_pkg::cdl_merge(addend, WB_DAT_I, WB_SEL_I);
      end
   end

   // accumulator write path, allowed while counting
   assign acc_io.wr     = wr_req && (WB_ADR_I == `CDL_OFS_ACCUM); // R17
   assign acc_io.wdata  = cdl_pkg::cdl_merge(acc_io.accum, WB_DAT_I, WB_SEL_I);
   assign acc_io.addend = addend;
   assign acc_io.acc_en = acc_en;

   // pin sample registers
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         first_s1  <= 1'b0;
         first_s2  <= 1'b0;
         second_s1 <= 1'b0;
      end else begin
         first_s1  <= FIRST_PIN_I; // R7 R11
         first_s2  <= first_s1; // R12
         second_s1 <= SECOND_PIN_I; // R7
      end
   end

   cdl_cond u_cond (
      .mode      (counter_mode_field),
      .first_s1  (first_s1),
      .first_s2  (first_s2),
      .second_s1 (second_s1),
      .grp       (grp),
      .acc_en    (acc_en)
   );

   cdl_accum u_accum (
      .CORE_CLK (CORE_CLK),
      .RESETN   (RESETN),
      .acc_io   (acc_io)
   );

   // pin drive selection
   always_comb begin
      next_first_o  = 1'b0;
      next_second_o = 1'b0;
      unique case (grp)
         cdl_pkg::CDL_GRP_NCO: begin
            next_first_o  = acc_io.next_accum[31]; // R15
            next_second_o = ~acc_io.next_accum[31]; // R15
         end
         cdl_pkg::CDL_GRP_DUTY: begin
            next_first_o  = acc_io.carry; // R1 R3
            next_second_o = ~acc_io.carry; // R16
         end
         cdl_pkg::CDL_GRP_PIN: begin
            next_first_o  = 1'b0;
            next_second_o = ~FIRST_PIN_I; // R13
         end
         default: begin
            next_first_o  = 1'b0;
            next_second_o = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         FIRST_PIN_O  <= 1'b0;
         SECOND_PIN_O <= 1'b0;
         carry_q      <= 1'b0;
      end else begin
         FIRST_PIN_O  <= next_first_o;
         SECOND_PIN_O <= next_second_o;
         carry_q      <= acc_io.carry;
      end
   end

   // pins driven only in output roles; logic modes leave both as inputs
   assign FIRST_PIN_OE  = (grp == cdl_pkg::CDL_GRP_NCO) ||
                          (grp == cdl_pkg::CDL_GRP_DUTY); // R4
   assign SECOND_PIN_OE = (counter_mode_field == `CDL_MODE_NCO_DIFF) ||
                          (counter_mode_field == `CDL_MODE_DUTY_DIFF) ||
                          ((grp == cdl_pkg::CDL_GRP_PIN) && counter_mode_field[0]); // R13 R16
endmodule : cdl_counter

// ### tb/cdl_counter_sva.sv
`timescale 1ns/1ps
`include "cdl_params.svh"
module cdl_counter_sva (
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESETN,
   // bus
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic        WB_ACK_O,
   // pins
   input wire logic        FIRST_PIN_I,
   input wire logic        FIRST_PIN_O,
   input wire logic        FIRST_PIN_OE,
   input wire logic        SECOND_PIN_O,
   input wire logic        SECOND_PIN_OE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   logic [4:0] mode;
   logic       take;
   logic       fb;
   logic       dif;
   assign take = WB_CYC_I & WB_STB_I & !WB_ACK_O;
   assign fb   = mode[4:3] == 2'h1 && mode[0];
   assign dif  = mode == 5'h05 || mode == 5'h07;
   // shadow of the mode field, same edge as the write
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode <= `CDL_RST_MODE;
      end else if (take && WB_WE_I && WB_ADR_I == `CDL_OFS_CTRL && WB_SEL_I[3]) begin
         mode <= WB_DAT_I[`CDL_CTRL_MODE_HI:`CDL_CTRL_MODE_LO];
      end
   end
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held past one cycle");
   a_ack_answer: assert property (take |=> WB_ACK_O)
      else $error("request not answered next cycle");
   a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
      else $error("ack without request");
   a_logic_inputs: assert property (
      $stable(mode) && mode[4] |-> !FIRST_PIN_OE && !SECOND_PIN_OE)
      else $error("pin driven in logic mode");
   a_first_drive: assert property (
      $stable(mode) |-> FIRST_PIN_OE == (mode[4:2] == 3'h1))
      else $error("first pin enable wrong");
   a_second_drive: assert property (
      $stable(mode) |-> SECOND_PIN_OE == (dif || fb))
      else $error("second pin enable wrong");
   a_feedback_inv: assert property (
      $stable(mode) && fb |-> SECOND_PIN_O == !$past(FIRST_PIN_I))
      else $error("feedback not inverse of first pin");
   a_diff_inverse: assert property (
      $stable(mode) && dif |-> SECOND_PIN_O == !FIRST_PIN_O)
      else $error("differential output not inverted");
endmodule : cdl_counter_sva

bind cdl_counter cdl_counter_sva i_cdl_counter_sva (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
   .FIRST_PIN_I(FIRST_PIN_I), .FIRST_PIN_O(FIRST_PIN_O), .FIRST_PIN_OE(FIRST_PIN_OE),
   .SECOND_PIN_O(SECOND_PIN_O), .SECOND_PIN_OE(SECOND_PIN_OE));

// ### tb/cdl_pins_model.sv
`timescale 1ns/1ps
module cdl_pins_model (
   // device side
   input  wire logic first_o,
   input  wire logic first_oe,
   input  wire logic second_o,
   input  wire logic second_oe,
   // external sources
   input  wire logic first_lvl,
   input  wire logic second_lvl,
   // resolved pin levels
   output logic      first_i,
   output logic      second_i
);
   // outside source only shows while the device lets go
   assign first_i  = first_oe ? first_o : first_lvl;
   assign second_i = second_oe ? second_o : second_lvl;
endmodule : cdl_pins_model

// ### tb/test_cdl_counter.sv
`timescale 1ns/1ps
module test_cdl_counter;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, lva = 0, lvb = 0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0, v0, v1, d, dout;
   logic [4:0]  m;
   logic        ack, ao, aoe, bo, boe, ai, bi;
   int          bad_count = 0, comparisons = 0, cyc_n = 0, hi, hb;

   initial forever #25 clk = ~clk;

   cdl_counter i_cdl_counter (.CORE_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(dout), .WB_ACK_O(ack), .FIRST_PIN_I(ai), .FIRST_PIN_O(ao),
      .FIRST_PIN_OE(aoe), .SECOND_PIN_I(bi), .SECOND_PIN_O(bo), .SECOND_PIN_OE(boe));
   cdl_pins_model i_cdl_pins_model (.first_o(ao), .first_oe(aoe), .second_o(bo),
      .second_oe(boe), .first_lvl(lva), .second_lvl(lvb), .first_i(ai), .second_i(bi));

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x,
                     output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= x;
      do @(posedge clk); while (ack !== 1'b1);
      q = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic cfg(input logic [4:0] md, input logic [31:0] add);
      wb(1'b1, 8'h04, add, v0);
      wb(1'b1, 8'h00, {1'b0, md, 26'h0}, v0);
   endtask : cfg

   // accumulator growth between two back-to-back reads
   task automatic dlt(output logic [31:0] q);
      wb(1'b0, 8'h08, 32'h0, v0);
      wb(1'b0, 8'h08, 32'h0, v1);
      q = v1 - v0;
   endtask : dlt

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task results;
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 4000) begin
         bad_count++;
         results;
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, 8'h20, 32'h0, v0);
      chk(v0, 32'h0);
      wb(1'b1, 8'h08, 32'hFFFF_FFFE, v0);
      wb(1'b0, 8'h08, 32'h0, v0);
      chk(v0, 32'hFFFF_FFFE);
      cfg(5'h1F, 32'h0000_0001);
      dlt(d);
      chk(d, 32'h0000_0003);
      $display("test registers done");
      // table index is {second, first}; edge modes see no edge here
      for (int mi = 8; mi < 32; mi++) begin
         for (int p = 0; p < 4; p++) begin
            m = mi[4:0];
            lva <= p[0];
            lvb <= p[1];
            cfg(m, 32'h0000_0007);
            dlt(d);
            chk(d, (m[4] ? m[p[1:0]] : !m[1] && (p[0] ^ m[2])) ? 32'h15 : 32'h0);
         end
      end
      $display("test logic and level done");
      for (int k = 0; k < 4; k++) begin
         m = 5'h0A | {2'b00, k[0], 1'b0, k[1]};
         lva <= m[2];
         cfg(m, 32'h0000_0007);
         wb(1'b0, 8'h08, 32'h0, v0);
         lva <= !m[2];
         repeat (4) @(posedge clk);
         wb(1'b0, 8'h08, 32'h0, v1);
         chk(v1 - v0, 32'h0000_0007);
      end
      $display("test edges done");
      for (int k = 0; k < 4; k++) begin
         m = 5'h04 + k[4:0];
         cfg(m, 32'h4000_0000);
         hi = 0;
         hb = 0;
         repeat (32) begin
            @(posedge clk);
            hi += ao;
            hb += bo;
         end
         chk(32'(hi), m[1] ? 32'h8 : 32'h10);
         chk(32'(hb), m[1] ? 32'h18 : 32'h10);
      end
      $display("test outputs done");
      results;
   end
endmodule : test_cdl_counter
